// file: core/gpio_ports_params.svh
// Offsets, reset values and field positions of the general-purpose port block.
// Assumes inclusion by bare name from the design module.
`ifndef GPIO_PORTS_PARAMS_SVH
`define GPIO_PORTS_PARAMS_SVH
`define P9_LATCH_ADDR 16'hFFDC
`define PB_LEVELS_ADDR 16'hFFDD
`define P9_DIR_ADDR 16'hFFEC
`define P9_LATCH_RESET 8'hC0
`define P9_DIR_RESET 8'hC0
`define P9_RSV_ONES 8'hC0
`define P9_PIN_MASK 8'h1F
`define P9_FLASH_MASK 8'h1E
`define DIR_READ_VALUE 8'hFF
`define ADDR_HI_MASK 32'hFFFF0000
`endif

// file: core/gpio_ports_pkg.sv
// Types shared by the general-purpose port block and its bench.
// Assumes nothing beyond the params header.
package gpio_ports_pkg;
  typedef enum logic [2:0]
  {
    MODE_ACTIVE,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_WATCH,
    MODE_STANDBY
  } op_mode_t;
  typedef struct packed
  {
    logic [4:0] o;
    logic [4:0] oe_n;
  } p9_pins_t;
  typedef struct packed
  {
    logic [7:0] o;
    logic [7:0] oe_n;
  } p8_pins_t;
endpackage : gpio_ports_pkg

// file: core/gpio_ports.sv
// Two port groups behind an AHB-Lite slave, plus low-power pin gating of ports 9 and 8.
// Assumes pin inputs synchronous to hclk and one slave on the bus.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "gpio_ports_params.svh"

// Summary of operation
// - Five bidirectional pins, each direction selectable
// - Latch bits 4..0 drive output pins
// - Latch bits 7,6 read 1, unwritable
// - Latch bit 5 reads 0, unwritable
// - Flash variant: latch bit 0 reads 0
// - Output pin reads back latch value
// - Input pin reads sampled pin level
// - Latch resets to C0
// - Direction 1 output, 0 input
// - Direction write-only, reads ones, resets C0
// - Port 9 hi-Z reset/standby, hold sleep/watch
// - Port 8 same per-mode pin states
// - Eight input-only pins shared with analog
// - Input port reads pin levels, read-only
// - Selected analog channel pin reads 0
// - Input-only pins never driven
module gpio_ports #(
  parameter bit FLASH_VARIANT = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire gpio_ports_pkg::op_mode_t op_mode,
  input wire logic [4:0] p9_in,
  output gpio_ports_pkg::p9_pins_t p9_pins,
  input wire logic [7:0] p8_out_func,
  input wire logic [7:0] p8_dir_func,
  output gpio_ports_pkg::p8_pins_t p8_pins,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] analog_input_channel,
  input wire logic analog_sel_valid,
  input wire logic [2:0] analog_channel_select
);

  // ************************************************
  // Bus slave
  // ************************************************
  logic [7:0] port9_output_latch_r;
  logic [7:0] port9_direction_control_r;
  logic [15:0] addr_r;
  logic wr_r;
  wire addr_phase = hsel && hready && htrans[1];
  wire addr_ok = (haddr & `ADDR_HI_MASK) == 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r <= 16'h0000;
      wr_r <= 1'b0;
    end
    else
    begin
      addr_r <= haddr[15:0];
      wr_r <= addr_phase && hwrite && addr_ok;
    end
  end

  function automatic logic hit(input logic [15:0] a, input logic [15:0] t);
    hit = (a == t);
  endfunction : hit

  wire wr_latch = wr_r && hit(addr_r, `P9_LATCH_ADDR);
  wire wr_dir = wr_r && hit(addr_r, `P9_DIR_ADDR);

  // ************************************************
  // Port 9 registers
  // ************************************************
  wire [7:0] keep_mask = FLASH_VARIANT ? `P9_FLASH_MASK : `P9_PIN_MASK;
  wire [7:0] latch_nxt = (hwdata[7:0] & keep_mask) | `P9_RSV_ONES;
  wire [7:0] dir_nxt = (hwdata[7:0] & `P9_PIN_MASK) | `P9_RSV_ONES;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port9_output_latch_r <= `P9_LATCH_RESET;
      port9_direction_control_r <= `P9_DIR_RESET;
    end
    else
    begin
      if (wr_latch)
        port9_output_latch_r <= latch_nxt;
      if (wr_dir)
        port9_direction_control_r <= dir_nxt;
    end
  end

  // ************************************************
  // Read path
  // ************************************************
  // Read data is launched at the address phase so it stands in the data phase
  wire rd_now = addr_phase && !hwrite && addr_ok;
  wire [15:0] rd_addr = haddr[15:0];
  // Forward a write that is landing at this edge to a back-to-back read
  wire [7:0] latch_view = wr_latch ? latch_nxt : port9_output_latch_r;
  wire [7:0] dir_view = wr_dir ? dir_nxt : port9_direction_control_r;
  wire [4:0] dir5 = port9_direction_control_r[4:0];
  wire [4:0] dir5_rd = dir_view[4:0];
  wire [4:0] p9_rd = (dir5_rd & latch_view[4:0]) | (~dir5_rd & p9_in);
  wire [4:0] p9_rd_m = p9_rd & keep_mask[4:0];
  wire [7:0] p9_word = {2'b11, 1'b0, p9_rd_m};
  wire [7:0] an_mask = analog_sel_valid ? (8'h01 << analog_channel_select) : 8'h00;
  wire [7:0] pb_word = pb_in & ~an_mask;
  wire [7:0] rd_byte = hit(rd_addr, `P9_LATCH_ADDR) ? p9_word :
                       hit(rd_addr, `PB_LEVELS_ADDR) ? pb_word :
                       hit(rd_addr, `P9_DIR_ADDR) ? `DIR_READ_VALUE :
                       8'h00;
  wire [31:0] hrdata_nxt = rd_now ? {24'h000000, rd_byte} : 32'h00000000;

  // ************************************************
  // Pin drive per mode
  // ************************************************
  wire mode_off = (op_mode == gpio_ports_pkg::MODE_STANDBY);
  wire mode_hold = (op_mode == gpio_ports_pkg::MODE_SLEEP) ||
                   (op_mode == gpio_ports_pkg::MODE_SUBSLEEP) ||
                   (op_mode == gpio_ports_pkg::MODE_WATCH);
  gpio_ports_pkg::p9_pins_t p9_nxt;
  gpio_ports_pkg::p8_pins_t p8_nxt;

  always_comb
  begin
    p9_nxt = p9_pins;
    p8_nxt = p8_pins;
    if (mode_off)
    begin
      p9_nxt.o = 5'h00;
      p9_nxt.oe_n = 5'h1F;
      p8_nxt.o = 8'h00;
      p8_nxt.oe_n = 8'hFF;
    end
    else if (!mode_hold)
    begin
      p9_nxt.o = port9_output_latch_r[4:0];
      p9_nxt.oe_n = ~dir5;
      p8_nxt.o = p8_out_func;
      p8_nxt.oe_n = ~p8_dir_func;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      p9_pins <= '{o: 5'h00, oe_n: 5'h1F};
      p8_pins <= '{o: 8'h00, oe_n: 8'hFF};
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      p9_pins <= p9_nxt;
      p8_pins <= p8_nxt;
      hrdata <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Port B pins have no drive path at all.
  wire [7:0] unused_an = analog_input_channel;

endmodule : gpio_ports

// file: tb/gpio_ports_asserts.sv
// Port block checker; bound to gpio_ports in tb_top.
`timescale 1ns/100ps
module gpio_ports_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire gpio_ports_pkg::op_mode_t op_mode,
  input wire logic [7:0] p8_dir_func,
  input wire gpio_ports_pkg::p9_pins_t p9_pins,
  input wire gpio_ports_pkg::p8_pins_t p8_pins
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire sb = op_mode == gpio_ports_pkg::MODE_STANDBY;
  wire fn = op_mode inside {gpio_ports_pkg::MODE_ACTIVE, gpio_ports_pkg::MODE_SUBACTIVE};
  wire hd = !sb && !fn;
  property p_sb9; sb |=> &p9_pins.oe_n; endproperty
  a_sb9: assert property (p_sb9) else $error("p9 driven");
  property p_sb8; sb |=> &p8_pins.oe_n; endproperty
  a_sb8: assert property (p_sb8) else $error("p8 driven");
  property p_hd9; hd ##1 hd |=> $stable(p9_pins); endproperty
  a_hd9: assert property (p_hd9) else $error("p9 not held");
  property p_hd8; hd ##1 hd |=> $stable(p8_pins); endproperty
  a_hd8: assert property (p_hd8) else $error("p8 not held");
  property p_fn8; fn |=> p8_pins.oe_n == ~$past(p8_dir_func); endproperty
  a_fn8: assert property (p_fn8) else $error("p8 dir");
  property p_rst;
    @(posedge hclk) disable iff (1'b0) !hresetn ##1 !hresetn |-> &p9_pins.oe_n && &p8_pins.oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("pins driven in reset");
  property p_rel; $rose(hresetn) |-> &p9_pins.oe_n; endproperty
  a_rel: assert property (p_rel) else $error("dir reset");
  property p_dir; rd && haddr == 32'h0000FFEC |=> hrdata == 32'h000000FF; endproperty
  a_dir: assert property (p_dir) else $error("dir read");
  property p_rsv; rd && haddr == 32'h0000FFDC |=> hrdata[7:5] == 3'h6; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  c_sb: cover property (sb);
  c_hd: cover property (hd ##1 hd);
  c_rd: cover property (rd);
endmodule : gpio_ports_asserts

// file: tb/board_pins.sv
// Board side of port 9; pins resolve to the driver or the board level.
`timescale 1ns/100ps
module board_pins (
  input wire gpio_ports_pkg::p9_pins_t p9_pins,
  input wire logic [4:0] ext,
  output logic [4:0] p9_in
);
  assign p9_in = (p9_pins.o & ~p9_pins.oe_n) | (ext & p9_pins.oe_n);
endmodule : board_pins

// file: tb/tb_top.sv
// Self-checking bench; assumes board_pins and the bound checker.
`timescale 1ns/100ps
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sv = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp;
  logic [4:0] ext = '0, p9_in;
  logic [7:0] pb_in = 8'hA5, p8_dir = 8'hF0;
  logic [2:0] ch = '0;
  gpio_ports_pkg::op_mode_t op_mode = gpio_ports_pkg::MODE_ACTIVE;
  gpio_ports_pkg::p9_pins_t p9_pins;
  gpio_ports_pkg::p8_pins_t p8_pins;
  int errors = 0, comparisons = 0;
  always #2.5 hclk = ~hclk;
  gpio_ports dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_mode, .p9_in,
    .p9_pins, .p8_out_func(8'h5A), .p8_dir_func(p8_dir), .p8_pins, .pb_in,
    .analog_input_channel(8'h00), .analog_sel_valid(sv), .analog_channel_select(ch));
  board_pins board (.p9_pins, .ext, .p9_in);
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin errors++; $display("[ERR] %0t %h %h", $time, g, e); end
  endtask : chk
  task automatic xf(input logic w, input logic [31:0] a, d);
    @(posedge hclk) {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xf
  task automatic rd(input logic [31:0] a, e);
    xf(0, a, 0);
    chk(q, e);
  endtask : rd
  task automatic conclude();
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    rd(32'hFFDC, 32'hC0);
    rd(32'hFF00, 32'h00);
    xf(1, 32'hFFDC, 32'hFF);
    xf(1, 32'hFFEC, 32'h1F);
    rd(32'hFFDC, 32'hDF);
    rd(32'hFFEC, 32'hFF);
    chk(p9_pins, 10'h3E0);
    ext <= 5'h0A;
    xf(1, 32'hFFEC, 32'h00);
    rd(32'hFFDC, 32'hCA);
    rd(32'hFFDD, 32'hA5);
    {sv, ch} <= 4'hA;
    xf(1, 32'hFFDD, 32'h00);
    rd(32'hFFDD, 32'hA1);
    xf(1, 32'hFFEC, 32'h1F);
    op_mode <= gpio_ports_pkg::MODE_SLEEP;
    xf(1, 32'hFFDC, 32'h00);
    chk(p9_pins.o, 32'h1F);
    op_mode <= gpio_ports_pkg::MODE_STANDBY;
    repeat (2) @(posedge hclk);
    chk(p9_pins.oe_n, 32'h1F);
    chk(p8_pins.oe_n, 32'hFF);
    op_mode <= gpio_ports_pkg::MODE_WATCH;
    repeat (3) @(posedge hclk);
    op_mode <= gpio_ports_pkg::MODE_SUBACTIVE;
    repeat (2) @(posedge hclk);
    chk(p9_pins, 10'h000);
    chk(p8_pins.oe_n, 32'h0F);
    conclude();
  end
  initial begin #20us; errors++; conclude(); end
endmodule : tb_top
bind gpio_ports gpio_ports_asserts chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .op_mode, .p8_dir_func, .p9_pins, .p8_pins);
